// file: logic/swc_sleep_wake.sv
// Sleep entry and wake-up controller with an APB register slave.
// Assumes core requests and wake sources are pulses or levels on pclk;
// the external send-event input comes from another core and is synchronised.
module swc_sleep_wake (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core side
    input wire swc_pkg::swc_core_req_t core_req,
    input wire swc_pkg::swc_wake_src_t wake_src,
    input wire logic send_event_pin,
    // Power outputs
    output logic sleeping,
    output logic deep_sleep,
    output logic cpu_clk_en,
    output logic wake_pulse,
    output logic handler_allowed,
    output logic wfe_skipped
);

    // Register state
    logic [31:0] sys_ctrl_q;
    logic global_interrupt_mask_bit_q;
    logic event_flag_q;
    logic evt_meta_q;
    logic evt_sync_q;
    logic evt_prev_q;
    swc_pkg::swc_cause_t cause_q;
    logic sleeping_q;
    logic deep_q;
    logic wake_q;
    logic skip_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic clk_en_q;
    logic allowed_q;

    // Control bits
    wire logic return_to_sleep_bit = sys_ctrl_q[swc_pkg::RTS_POS];
    wire logic deep_sleep_select_bit = sys_ctrl_q[swc_pkg::DEEP_POS];
    wire logic pending_wake_event_bit = sys_ctrl_q[swc_pkg::PEND_WAKE_POS];

    // APB decode; zero wait states
    wire logic apb_acc = psel & penable;
    wire logic apb_wr = apb_acc & pwrite;
    wire logic hit_ctrl = (paddr == swc_pkg::SYS_CTRL_OFF);
    wire logic hit_mask = (paddr == swc_pkg::MASK_OFF);
    wire logic hit_stat = (paddr == swc_pkg::STATUS_OFF);
    wire logic hit_any = hit_ctrl | hit_mask | hit_stat;

    // Rising edge of synchronised send-event; only the second stage is read
    wire logic send_event_rise = evt_sync_q & ~evt_prev_q;
    // Events that set the one-bit event register
    wire logic event_raise = send_event_rise | wake_src.send_event_in
                           | (pending_wake_event_bit & wake_src.new_pending);

    // Sleep entry decisions while awake
    wire logic enter_wfi = ~sleeping_q & core_req.wait_interrupt_instr;
    wire logic enter_exit = ~sleeping_q & ~core_req.wait_interrupt_instr
                          & core_req.handler_return_thread & return_to_sleep_bit;
    wire logic wfe_seen = ~sleeping_q & ~core_req.wait_interrupt_instr
                        & ~enter_exit & core_req.wait_event_instr;
    wire logic enter_wfe = wfe_seen & ~event_flag_q;
    wire logic skip_wfe = wfe_seen & event_flag_q;

    // Wake with the mask set: enabled higher-priority irq wakes the core
    wire logic masked_wake = global_interrupt_mask_bit_q & wake_src.irq_enabled_hi;
    // Wake condition chosen by recorded cause
    wire logic wake_irq = wake_src.exc_entry_ok | masked_wake;
    wire logic wake_evt = wake_irq | event_raise;
    wire logic wake_now = sleeping_q &
        ((cause_q == swc_pkg::SWC_CAUSE_WFE) ? wake_evt : wake_irq);

    // Read mux
    wire logic [31:0] status_word = {26'h0, event_flag_q, deep_q, cause_q, sleeping_q,
                                     global_interrupt_mask_bit_q};
    wire logic [31:0] rd_word = hit_ctrl ? sys_ctrl_q :
                                hit_mask ? {31'h0, global_interrupt_mask_bit_q} :
                                hit_stat ? status_word : 32'h0000_0000;
    // Writable control bits; the rest read back as zero so software can probe the layout
    wire logic [31:0] ctrl_wmask = (32'h0000_0001 << swc_pkg::RTS_POS)
                                 | (32'h0000_0001 << swc_pkg::DEEP_POS)
                                 | (32'h0000_0001 << swc_pkg::PEND_WAKE_POS);

    // Synchroniser for the other core's send-event line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_meta_q <= 1'b0;
            evt_sync_q <= 1'b0;
            evt_prev_q <= 1'b0;
        end else begin
            evt_meta_q <= send_event_pin;
            evt_sync_q <= evt_meta_q;
            evt_prev_q <= evt_sync_q;
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_ctrl_q <= swc_pkg::SYS_CTRL_RST;
            global_interrupt_mask_bit_q <= swc_pkg::MASK_RST;
            allowed_q <= ~swc_pkg::MASK_RST;
        end else if (apb_wr) begin
            if (hit_ctrl) begin
                sys_ctrl_q <= pwdata & ctrl_wmask;
            end
            if (hit_mask) begin
                global_interrupt_mask_bit_q <= pwdata[0];
                allowed_q <= ~pwdata[0];
            end
        end
    end

    // Event register: raise wins over the skip clear so no event is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_flag_q <= 1'b0;
        end else if (event_raise) begin
            event_flag_q <= 1'b1;
        end else if (skip_wfe) begin
            event_flag_q <= 1'b0;
        end
    end

    // Sleep state and recorded cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleeping_q <= 1'b0;
            cause_q <= swc_pkg::SWC_CAUSE_NONE;
            deep_q <= 1'b0;
            clk_en_q <= 1'b1;
        end else if (wake_now) begin
            sleeping_q <= 1'b0;
            cause_q <= swc_pkg::SWC_CAUSE_NONE;
            deep_q <= 1'b0;
            clk_en_q <= 1'b1;
        end else if (enter_wfi | enter_exit | enter_wfe) begin
            sleeping_q <= 1'b1;
            clk_en_q <= 1'b0;
            cause_q <= enter_wfi ? swc_pkg::SWC_CAUSE_WFI :
                       enter_exit ? swc_pkg::SWC_CAUSE_EXIT :
                       swc_pkg::SWC_CAUSE_WFE;
            deep_q <= deep_sleep_select_bit;
        end
    end

    // One-cycle pulses and APB answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q <= 1'b0;
            skip_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            wake_q <= wake_now;
            skip_q <= skip_wfe;
            prdata_q <= (psel & ~penable & ~pwrite) ? rd_word : prdata_q;
            pslverr_q <= psel & ~penable & ~hit_any;
        end
    end

    // Outputs other than pready (tied high) come from flip-flops; clock enable is low only while asleep
    assign sleeping = sleeping_q;
    assign deep_sleep = deep_q;
    assign cpu_clk_en = clk_en_q;
    assign wake_pulse = wake_q;
    assign handler_allowed = allowed_q;
    assign wfe_skipped = skip_q;
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = pslverr_q;

    // Interrupt-wait enters sleep the next edge
    property p_wfi_sleep;
        @(posedge pclk) disable iff (!presetn)
        enter_wfi |=> sleeping && cause_q == swc_pkg::SWC_CAUSE_WFI;
    endproperty
    a_wfi_sleep: assert property (p_wfi_sleep) else $error("wfi did not sleep");

    property p_exit_sleep;
        @(posedge pclk) disable iff (!presetn)
        enter_exit |=> sleeping && cause_q == swc_pkg::SWC_CAUSE_EXIT;
    endproperty
    a_exit_sleep: assert property (p_exit_sleep) else $error("no sleep on exit");

    property p_wfi_no_evt_wake;
        @(posedge pclk) disable iff (!presetn)
        (sleeping && cause_q != swc_pkg::SWC_CAUSE_WFE && !wake_src.exc_entry_ok
         && !masked_wake) |=> sleeping;
    endproperty
    a_wfi_no_evt_wake: assert property (p_wfi_no_evt_wake) else $error("bad wake");

    property p_exc_wake;
        @(posedge pclk) disable iff (!presetn)
        (sleeping && wake_src.exc_entry_ok) |=> !sleeping ##0 wake_pulse;
    endproperty
    a_exc_wake: assert property (p_exc_wake) else $error("exception did not wake");

    property p_mask_wake;
        @(posedge pclk) disable iff (!presetn)
        (sleeping && masked_wake) |=> !sleeping && !handler_allowed;
    endproperty
    a_mask_wake: assert property (p_mask_wake) else $error("masked wake wrong");

    property p_sev_wake;
        @(posedge pclk) disable iff (!presetn)
        (sleeping && cause_q == swc_pkg::SWC_CAUSE_WFE && event_raise) |=> !sleeping;
    endproperty
    a_sev_wake: assert property (p_sev_wake) else $error("event did not wake");

    property p_pend_evt;
        @(posedge pclk) disable iff (!presetn)
        (pending_wake_event_bit && wake_src.new_pending && !sleeping_q) |=> event_flag_q;
    endproperty
    a_pend_evt: assert property (p_pend_evt) else $error("pending lost");

    property p_wfe_skip;
        @(posedge pclk) disable iff (!presetn)
        (skip_wfe && !event_raise) |=> !event_flag_q && !sleeping && wfe_skipped;
    endproperty
    a_wfe_skip: assert property (p_wfe_skip) else $error("wfe skip wrong");

    property p_deep;
        @(posedge pclk) disable iff (!presetn)
        (enter_wfi || enter_exit || enter_wfe) |=> deep_sleep == $past(deep_sleep_select_bit);
    endproperty
    a_deep: assert property (p_deep) else $error("deep select wrong");

    property p_clk_gate;
        @(posedge pclk) disable iff (!presetn)
        (sleeping && !wake_now) |=> !cpu_clk_en && $stable(cause_q);
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock not gated");

    property p_cause_wake;
        @(posedge pclk) disable iff (!presetn)
        (sleeping && cause_q == swc_pkg::SWC_CAUSE_WFI && event_raise && !wake_irq) |=> sleeping;
    endproperty
    a_cause_wake: assert property (p_cause_wake) else $error("cause ignored");

    // Clock enable flop must mirror the sleep flop, or the core runs while asleep
    property p_clk_en_track;
        @(posedge pclk) disable iff (!presetn)
        cpu_clk_en != sleeping;
    endproperty
    a_clk_en_track: assert property (p_clk_en_track) else $error("clock enable skew");

    // Handler gate follows the mask bit from the same write edge
    property p_handler_track;
        @(posedge pclk) disable iff (!presetn)
        handler_allowed != global_interrupt_mask_bit_q;
    endproperty
    a_handler_track: assert property (p_handler_track) else $error("handler gate skew");

    // Handler return with the sleep bit clear resumes thread code
    property p_no_rts;
        @(posedge pclk) disable iff (!presetn)
        (!sleeping_q && core_req.handler_return_thread && !return_to_sleep_bit
         && !core_req.wait_interrupt_instr && !core_req.wait_event_instr) |=> !sleeping;
    endproperty
    a_no_rts: assert property (p_no_rts) else $error("slept without sleep bit");

    // Event-wait with a clear flag sleeps and records its cause
    property p_wfe_enter;
        @(posedge pclk) disable iff (!presetn)
        enter_wfe |=> sleeping && cause_q == swc_pkg::SWC_CAUSE_WFE && !wfe_skipped;
    endproperty
    a_wfe_enter: assert property (p_wfe_enter) else $error("wfe did not sleep");

    // Any event sets the flag, even in the cycle of a skip clear
    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        event_raise |=> event_flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag lost");

    // Sleep depth is fixed at entry and kept until wake-up
    property p_deep_hold;
        @(posedge pclk) disable iff (!presetn)
        (sleeping && !wake_now) |=> $stable(deep_sleep);
    endproperty
    a_deep_hold: assert property (p_deep_hold) else $error("depth changed asleep");

    // Wake-up restores the clock and marks the resume for one cycle
    property p_wake_resume;
        @(posedge pclk) disable iff (!presetn)
        wake_now |=> wake_pulse && cpu_clk_en;
    endproperty
    a_wake_resume: assert property (p_wake_resume) else $error("resume incomplete");

endmodule

// file: logic/swc_pkg.sv
// Package for the sleep and wake controller: APB map, field layout, states.
// Assumes a 32-bit APB slave with word-aligned registers.
package swc_pkg;

    // Register byte offsets
    localparam logic [7:0] SYS_CTRL_OFF = 8'h00;
    localparam logic [7:0] MASK_OFF = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;

    // Bit positions in the system control register
    localparam int RTS_POS = 1;
    localparam int DEEP_POS = 2;
    localparam int PEND_WAKE_POS = 4;

    // Values after reset
    localparam logic [31:0] SYS_CTRL_RST = 32'h0000_0000;
    localparam logic MASK_RST = 1'b0;

    // Sleep entry cause, kept while asleep
    typedef enum logic [1:0] {
        SWC_CAUSE_NONE,
        SWC_CAUSE_WFI,
        SWC_CAUSE_EXIT,
        SWC_CAUSE_WFE
    } swc_cause_t;

    // Requests from the core
    typedef struct packed {
        logic wait_interrupt_instr;
        logic wait_event_instr;
        logic handler_return_thread;
    } swc_core_req_t;

    // Wake sources from the interrupt side
    typedef struct packed {
        logic exc_entry_ok;
        logic irq_enabled_hi;
        logic new_pending;
        logic send_event_in;
    } swc_wake_src_t;

endpackage

// file: testbench/swc_src_model.sv
// Model of interrupt sources and of a neighbouring core that raises events.
// Assumes the bench pulses go for one pclk cycle to order one source.
module swc_src_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Orders from the bench
    input wire logic go,
    input wire logic [2:0] sel,
    input wire logic [3:0] dly,
    // Toward the controller
    output swc_pkg::swc_wake_src_t wake_src,
    output logic send_event_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    int pin_cnt;
    logic [2:0] sel_q;

    // Each source fires once after a chosen wait, so prompt and slow senders both occur
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= -1;
            pin_cnt <= 0;
            sel_q <= 3'h0;
            wake_src <= '0;
            send_event_pin <= 1'b0;
        end else begin
            wake_src <= '0;
            if (pin_cnt > 0) pin_cnt <= pin_cnt - 1;
            else send_event_pin <= 1'b0; // Idle low: the other core drops its line
            if (go) begin
                cnt <= int'(dly);
                sel_q <= sel;
            end else if (cnt == 0) begin
                cnt <= -1;
                case (sel_q)
                    3'h0: wake_src.exc_entry_ok <= 1'b1;
                    3'h1: wake_src.irq_enabled_hi <= 1'b1;
                    3'h2: wake_src.new_pending <= 1'b1;
                    3'h3: wake_src.send_event_in <= 1'b1;
                    default: begin
                        send_event_pin <= 1'b1;
                        pin_cnt <= 4;
                    end
                endcase
            end else if (cnt > 0) cnt <= cnt - 1;
        end
    end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the sleep and wake controller.
// Assumes the controller answers APB with no wait states; waits stay bounded anyway.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sleeping, deep_sleep, cpu_clk_en, wake_pulse, handler_allowed;
    logic wfe_skipped, send_event_pin, er;
    swc_pkg::swc_core_req_t core_req = '0;
    swc_pkg::swc_wake_src_t wake_src;
    logic go = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [3:0] dly = 4'h0;
    logic [31:0] rd;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    // Design and far-side model
    swc_sleep_wake i_swc_sleep_wake (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_req(core_req), .wake_src(wake_src),
        .send_event_pin(send_event_pin), .sleeping(sleeping), .deep_sleep(deep_sleep),
        .cpu_clk_en(cpu_clk_en), .wake_pulse(wake_pulse), .handler_allowed(handler_allowed),
        .wfe_skipped(wfe_skipped));
    swc_src_model i_swc_src_model (.pclk(pclk), .presetn(presetn), .go(go), .sel(sel),
        .dly(dly), .wake_src(wake_src), .send_event_pin(send_event_pin));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // Cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data is taken at the edge where pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    // Core request pulse, then look once the taking edge has landed
    task automatic core(input logic [2:0] v);
        @(posedge pclk);
        core_req <= v;
        @(posedge pclk);
        core_req <= '0;
        #1;
    endtask

    task automatic fire(input logic [2:0] s, input logic [3:0] d);
        @(posedge pclk);
        go <= 1'b1;
        sel <= s;
        dly <= d;
        @(posedge pclk);
        go <= 1'b0;
    endtask

    // Bounded wait for wake-up; the synchronised pin needs a few extra cycles
    task automatic wake();
        int n;
        n = 0;
        while (sleeping !== 1'b0 && n < 20) begin
            @(posedge pclk);
            #1;
            n++;
        end
        check(sleeping, 0);
        check(wake_pulse, 1);
        check(cpu_clk_en, 1);
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, swc_pkg::STATUS_OFF, 0);
        check(rd, 0);
        check({cpu_clk_en, handler_allowed}, 2'b11);
        apb(0, 8'h0C, 0);
        check(er, 1);
        check(rd, 0);
        apb(1, swc_pkg::SYS_CTRL_OFF, 32'hFFFF_FFFF);
        apb(0, swc_pkg::SYS_CTRL_OFF, 0);
        check(rd, 32'h16);
        check(er, 0);
        apb(1, swc_pkg::SYS_CTRL_OFF, 32'h10);
        core(3'b010);
        check({sleeping, cpu_clk_en}, 2'b10);
        apb(0, swc_pkg::STATUS_OFF, 0);
        check(rd, 32'h0E);
        fire(3'h3, 0);
        wake();
        core(3'b010);
        check({wfe_skipped, sleeping}, 2'b10);
        core(3'b010);
        fire(3'h4, 5);
        wake();
        core(3'b010);
        check({wfe_skipped, sleeping}, 2'b10);
        core(3'b010);
        fire(3'h2, 1);
        wake();
        core(3'b010);
        check({wfe_skipped, sleeping}, 2'b10);
        core(3'b010);
        fire(3'h0, 3);
        wake();
        fire(3'h2, 0);
        repeat (2) @(posedge pclk);
        core(3'b010);
        check({wfe_skipped, sleeping}, 2'b10);
        apb(1, swc_pkg::SYS_CTRL_OFF, 32'h14);
        core(3'b100);
        check({sleeping, deep_sleep}, 2'b11);
        apb(0, swc_pkg::STATUS_OFF, 0);
        check(rd, 32'h16);
        fire(3'h2, 0);
        fire(3'h3, 0);
        fire(3'h1, 0);
        repeat (4) @(posedge pclk);
        #1;
        check(sleeping, 1);
        apb(1, swc_pkg::MASK_OFF, 1);
        fire(3'h1, 2);
        wake();
        check(handler_allowed, 0);
        apb(1, swc_pkg::MASK_OFF, 0);
        check(handler_allowed, 1);
        apb(1, swc_pkg::SYS_CTRL_OFF, 0);
        core(3'b001);
        check(sleeping, 0);
        apb(1, swc_pkg::SYS_CTRL_OFF, 32'h02);
        core(3'b001);
        check({sleeping, cpu_clk_en, deep_sleep}, 3'b100);
        apb(0, swc_pkg::STATUS_OFF, 0);
        check(rd, 32'h2A);
        fire(3'h0, 6);
        check(cpu_clk_en, 0);
        wake();
        complete_run();
    end
endmodule
